/* design/usb_cmd_regs_dev.sv */
// device end: scratch, frame number, identity and interrupt source set
`timescale 1ns/10ps
`include "usb_cmd_regs_cfg.svh"
module usb_cmd_regs_dev #(
   parameter int PSEUDO_FRAME_TICK_CYCLES = `PSEUDO_FRAME_TICK_CYCLES
) (
   // clock and reset
   input  wire logic        clk,
   input  wire logic        reset_n,
   // processor bus
   usb_cmd_bus_if.dev       bus,
   // usb side events, one-cycle pulses
   input  wire logic        sof_det,
   input  wire logic [10:0] sof_frame,
   input  wire logic        resume_det,
   input  wire logic        bus_reset_det,
   // endpoint and dma events, one-cycle pulses
   input  wire logic [15:0] ep_event,
   input  wire logic        short_packet_transfer_end,
   input  wire logic        dma_transfer_end,
   // separate interrupt enable register contents
   input  wire logic [31:0] int_enable,
   // status out
   output logic             irq,
   output logic             bus_sleep_state
);

   localparam logic [14:0] TICK_LAST = 15'(PSEUDO_FRAME_TICK_CYCLES - 1);

   usb_cmd_regs_pkg::dev_state_t s_q;
   usb_cmd_regs_pkg::dev_state_t s_d;

   logic [31:0] ev_set;
   logic        tick;

   // word to return for a command and word index
   function automatic logic [15:0] read_word(
      input usb_cmd_regs_pkg::dev_state_t s
   );
      case (s.cmd)
         `CMD_SCRATCH_RD: read_word = {3'h0, s.scratch};
         `CMD_FRAME_RD:   read_word = {5'h00, s.frame};
         `CMD_IDENT_RD:   read_word = {`PART_CODE, `SILICON_VER};
         `CMD_INT_RD:
            read_word = s.word_idx ? s.flags[31:16] : s.flags[15:0];
         default:         read_word = 16'h0000;
      endcase
   endfunction : read_word

   // ---------------------------------------------------------------
   // event collection
   // ---------------------------------------------------------------
   always_comb begin
      tick   = (s_q.tick_cnt == TICK_LAST);
      ev_set = 32'h0000_0000;
      ev_set[`EP_FLAG_LSB +: `EP_FLAG_CNT] = ep_event;
      ev_set[`BIT_SHORT_PACKET_TRANSFER_END]     = short_packet_transfer_end;
      ev_set[`BIT_PSEUDO_SOF] = tick;
      ev_set[`BIT_SOF]        = sof_det;
      ev_set[`BIT_DMA_EOT]    = dma_transfer_end;
      ev_set[`BIT_RESUME]     = resume_det;
      ev_set[`BIT_BUS_RESET]  = bus_reset_det;
   end

   always_comb begin
      s_d        = s_q;
      s_d.rvalid = 1'b0;
      s_d.rdata  = 16'h0000;

      // ------------------------------------------------------------
      // pseudo frame tick and missed-frame watch
      // ------------------------------------------------------------
      s_d.tick_cnt = tick ? 15'h0000 : s_q.tick_cnt + 15'h0001;
      if (sof_det) begin
         s_d.sof_seen = 1'b1;
         s_d.missed   = 2'h0;
         s_d.frame    = sof_frame;
      end
      if (tick) begin
         s_d.sof_seen = sof_det;
         if (!s_q.sof_seen && !sof_det && s_q.missed != `MISSED_SOF_MAX)
         begin
            s_d.missed = s_q.missed + 2'h1;
         end
      end

      // ------------------------------------------------------------
      // bus sleep state
      // ------------------------------------------------------------
      if (!s_q.sleep && s_d.missed == `MISSED_SOF_MAX) begin
         s_d.sleep  = 1'b1;
         s_d.locked = 1'b1;
      end
      if (s_q.sleep && (resume_det || bus_reset_det || sof_det)) begin
         s_d.sleep  = 1'b0;
         s_d.missed = 2'h0;
      end

      // ------------------------------------------------------------
      // processor bus: command and data phases
      // ------------------------------------------------------------
      if (bus.wr && bus.command_data_select) begin
         s_d.cmd      = bus.wdata[7:0];
         s_d.word_idx = 1'b0;
      end else if (bus.wr) begin
         case (s_q.cmd)
            `CMD_SCRATCH_WR:
               if (!s_q.locked) begin
                  s_d.scratch = bus.wdata[`SCRATCH_INFO_W-1:0];
               end
            `CMD_UNLOCK:
               if (bus.wdata == `UNLOCK_CODE) begin
                  s_d.locked = 1'b0;
               end
            default: begin
            end
         endcase
      end else if (bus.rd && !bus.command_data_select) begin
         s_d.rvalid   = 1'b1;
         s_d.rdata    = read_word(s_q);
         s_d.word_idx = ~s_q.word_idx;
         // all sticky flags, both words, are cleared once the second word is handed over
         if (s_q.cmd == `CMD_INT_RD && s_q.word_idx) begin
            s_d.flags = s_d.flags & ~`STICKY_EVT_MASK;
         end
      end

      // ------------------------------------------------------------
      // sticky flags: a new event wins over a clear in the same cycle
      // ------------------------------------------------------------
      s_d.flags = (s_d.flags | (ev_set & `STICKY_EVT_MASK))
                  & `STICKY_EVT_MASK;
      if (!s_q.sleep && s_d.sleep) begin
         s_d.flags[`BIT_SLEEP_ENTRY] = 1'b1;
      end
      s_d.flags[`BIT_BUS_SLEEP] = s_d.sleep;
      s_d.irq = |(s_d.flags & int_enable & `STICKY_EVT_MASK);
   end

   always_ff @(posedge clk or negedge reset_n) begin
      if (!reset_n) begin
         s_q <= '{cmd: `CMD_NONE, default: '0};
      end else begin
         s_q <= s_d;
      end
   end

   assign bus.rdata       = s_q.rdata;
   assign bus.rvalid      = s_q.rvalid;
   assign irq             = s_q.irq;
   assign bus_sleep_state = s_q.sleep;

endmodule : usb_cmd_regs_dev

/* design/usb_cmd_regs_cfg.svh */
// constants of the command-addressed general register set and its host
`ifndef USB_CMD_REGS_CFG_SVH
`define USB_CMD_REGS_CFG_SVH

// command codes, carried on the low data byte of a command phase
`define CMD_UNLOCK      8'hB0
`define CMD_SCRATCH_WR  8'hB2
`define CMD_SCRATCH_RD  8'hB3
`define CMD_FRAME_RD    8'hB4
`define CMD_IDENT_RD    8'hB5
`define CMD_INT_RD      8'hC0
`define CMD_NONE        8'h00

`define UNLOCK_CODE     16'hAA37
`define SCRATCH_INFO_W  13
`define FRAME_W         11
`define WORD_W          16
`define FLAGS_W         32

// interrupt source bit positions
`define BIT_BUS_SLEEP   7
`define BIT_SHORT_PACKET_TRANSFER_END      6
`define BIT_PSEUDO_SOF  5
`define BIT_SOF         4
`define BIT_DMA_EOT     3
`define BIT_SLEEP_ENTRY 2
`define BIT_RESUME      1
`define BIT_BUS_RESET   0
`define EP_FLAG_LSB     8
`define EP_FLAG_CNT     16
`define STICKY_EVT_MASK 32'h00FF_FF7F

// identity word; values are arbitrary
`define PART_CODE       8'h5A
`define SILICON_VER     8'h01

// timing
`define CLK_PERIOD_NS   50
`define PSEUDO_FRAME_TICK_PERIOD_NS  1000000
`define PSEUDO_FRAME_TICK_CYCLES     (`PSEUDO_FRAME_TICK_PERIOD_NS / `CLK_PERIOD_NS)
`define TICK_CNT_W      15
`define MISSED_SOF_MAX  2'h3

// host command-port register offsets
`define HREG_CMD        4'h0
`define HREG_WDATA      4'h1
`define HREG_RDATA0     4'h2
`define HREG_RDATA1     4'h3
`define HREG_STATUS     4'h4

`endif

/* design/usb_cmd_regs_pkg.sv */
// types shared by the device register set and its host
package usb_cmd_regs_pkg;

   typedef struct packed {
      logic [7:0]  cmd;
      logic        word_idx;
      logic [12:0] scratch;
      logic [10:0] frame;
      logic [31:0] flags;
      logic        sleep;
      logic        locked;
      logic [14:0] tick_cnt;
      logic [1:0]  missed;
      logic        sof_seen;
      logic [15:0] rdata;
      logic        rvalid;
      logic        irq;
   } dev_state_t;

   typedef enum logic [1:0] {
      H_IDLE,
      H_CMD,
      H_DATA,
      H_WAIT
   } host_phase_t;

   typedef struct packed {
      host_phase_t phase;
      logic [7:0]  code;
      logic [1:0]  left;
      logic        cap_idx;
      logic [15:0] wd;
      logic [15:0] rd0;
      logic [15:0] rd1;
      logic        bus_sel;
      logic        bus_wr;
      logic        bus_rd;
      logic [15:0] bus_wdata;
      logic [15:0] user_rdata;
   } host_state_t;

endpackage : usb_cmd_regs_pkg

/* design/usb_cmd_bus_if.sv */
// shared parallel command/data bus between processor side and device
`timescale 1ns/10ps
interface usb_cmd_bus_if;
   logic        command_data_select;
   logic        wr;
   logic        rd;
   logic [15:0] wdata;
   logic [15:0] rdata;
   logic        rvalid;

   modport dev (
      input  command_data_select,
      input  wr,
      input  rd,
      input  wdata,
      output rdata,
      output rvalid
   );

   modport host (
      output command_data_select,
      output wr,
      output rd,
      output wdata,
      input  rdata,
      input  rvalid
   );
endinterface : usb_cmd_bus_if

/* design/usb_cmd_host.sv */
// processor-side end: runs command and data phases for software orders
`timescale 1ns/10ps
`include "usb_cmd_regs_cfg.svh"
module usb_cmd_host (
   // clock and reset
   input  wire logic        clk,
   input  wire logic        reset_n,
   // software register port
   input  wire logic [3:0]  addr,
   input  wire logic [15:0] wdata,
   input  wire logic        wr,
   input  wire logic        rd,
   output logic      [15:0] rdata,
   // device bus
   usb_cmd_bus_if.host      bus
);

   usb_cmd_regs_pkg::host_state_t s_q;
   usb_cmd_regs_pkg::host_state_t s_d;

   // data words that follow a command code
   function automatic logic [1:0] word_count(input logic [7:0] code);
      case (code)
         `CMD_INT_RD:     word_count = 2'h2;
         `CMD_UNLOCK,
         `CMD_SCRATCH_WR,
         `CMD_SCRATCH_RD,
         `CMD_FRAME_RD,
         `CMD_IDENT_RD:   word_count = 2'h1;
         default:         word_count = 2'h0;
      endcase
   endfunction : word_count

   function automatic logic is_write(input logic [7:0] code);
      is_write = (code == `CMD_UNLOCK) || (code == `CMD_SCRATCH_WR);
   endfunction : is_write

   always_comb begin
      s_d            = s_q;
      s_d.bus_sel    = 1'b0;
      s_d.bus_wr     = 1'b0;
      s_d.bus_rd     = 1'b0;
      s_d.user_rdata = 16'h0000;

      // --------------------------------------------------------------
      // software port
      // --------------------------------------------------------------
      if (rd) begin
         case (addr)
            `HREG_WDATA:  s_d.user_rdata = s_q.wd;
            `HREG_RDATA0: s_d.user_rdata = s_q.rd0;
            `HREG_RDATA1: s_d.user_rdata = s_q.rd1;
            `HREG_STATUS:
               s_d.user_rdata = {15'h0000,
                                 s_q.phase != usb_cmd_regs_pkg::H_IDLE};
            default:      s_d.user_rdata = 16'h0000;
         endcase
      end
      if (wr && addr == `HREG_WDATA) begin
         s_d.wd = wdata;
      end
      if (wr && addr == `HREG_CMD
          && s_q.phase == usb_cmd_regs_pkg::H_IDLE) begin
         s_d.code  = wdata[7:0];
         s_d.left  = word_count(wdata[7:0]);
         s_d.phase = usb_cmd_regs_pkg::H_CMD;
      end

      // read data arrive one cycle after each strobe
      if (bus.rvalid) begin
         if (s_q.cap_idx) begin
            s_d.rd1 = bus.rdata;
         end else begin
            s_d.rd0 = bus.rdata;
         end
         s_d.cap_idx = 1'b1;
      end

      // --------------------------------------------------------------
      // bus sequencer
      // --------------------------------------------------------------
      case (s_q.phase)
         usb_cmd_regs_pkg::H_IDLE: begin
         end
         usb_cmd_regs_pkg::H_CMD: begin
            // code on the low byte, upper byte left zero
            s_d.bus_sel   = 1'b1;
            s_d.bus_wr    = 1'b1;
            s_d.bus_wdata = {8'h00, s_q.code};
            s_d.cap_idx   = 1'b0;
            s_d.phase     = (s_q.left == 2'h0) ?
                            usb_cmd_regs_pkg::H_WAIT :
                            usb_cmd_regs_pkg::H_DATA;
         end
         usb_cmd_regs_pkg::H_DATA: begin
            if (is_write(s_q.code)) begin
               s_d.bus_wr = 1'b1;
               // reserved scratch bits always sent as zero
               s_d.bus_wdata = (s_q.code == `CMD_SCRATCH_WR) ?
                  {3'h0, s_q.wd[`SCRATCH_INFO_W-1:0]} : s_q.wd;
            end else begin
               s_d.bus_rd = 1'b1;
            end
            s_d.left = s_q.left - 2'h1;
            if (s_q.left == 2'h1) begin
               s_d.phase = usb_cmd_regs_pkg::H_WAIT;
            end
         end
         usb_cmd_regs_pkg::H_WAIT: begin
            s_d.phase = usb_cmd_regs_pkg::H_IDLE;
         end
         default: s_d.phase = usb_cmd_regs_pkg::H_IDLE;
      endcase
   end

   always_ff @(posedge clk or negedge reset_n) begin
      if (!reset_n) begin
         s_q <= '{phase: usb_cmd_regs_pkg::H_IDLE, code: `CMD_NONE,
                  default: '0};
      end else begin
         s_q <= s_d;
      end
   end

   assign rdata                   = s_q.user_rdata;
   assign bus.command_data_select = s_q.bus_sel;
   assign bus.wr                  = s_q.bus_wr;
   assign bus.rd                  = s_q.bus_rd;
   assign bus.wdata               = s_q.bus_wdata;

endmodule : usb_cmd_host

/* sim/usb_cmd_bus_chk.sv */
// assertions on the command/data bus joining the host and device ends
`timescale 1ns/10ps
`include "usb_cmd_regs_cfg.svh"
module usb_cmd_bus_chk (
   // clock and reset
   input wire logic        clk,
   input wire logic        reset_n,
   // bus signals
   input wire logic        command_data_select,
   input wire logic        wr,
   input wire logic        rd,
   input wire logic [15:0] wdata,
   input wire logic [15:0] rdata,
   input wire logic        rvalid
);
   logic [7:0] cmd_q;
   logic       idx_q;

   // tracks the current command and which word of it is next
   always_ff @(posedge clk or negedge reset_n) begin
      if (!reset_n) begin
         cmd_q <= 8'h00;
         idx_q <= 1'b0;
      end else if (wr && command_data_select) begin
         cmd_q <= wdata[7:0];
         idx_q <= 1'b0;
      end else if (rd && !command_data_select) begin
         idx_q <= !idx_q;
      end
   end

   // ------------------------------------------------------------
   // assertions
   // ------------------------------------------------------------
   default clocking cb @(posedge clk); endclocking
   default disable iff (!reset_n);

   read_answer_a: assert property (
      rd && !command_data_select |=> rvalid)
      else $error("data read not answered next cycle");
   answer_cause_a: assert property (
      rvalid |-> $past(rd && !command_data_select))
      else $error("read answer without a data read");
   idle_rdata_a: assert property (
      !rvalid |-> rdata == 16'h0000)
      else $error("read data not zero outside answer");
   strobe_excl_a: assert property (
      !(wr && rd))
      else $error("write and read strobes together");
   scratch_rsvd_a: assert property (
      rvalid && cmd_q == `CMD_SCRATCH_RD |-> rdata[15:13] == 3'h0)
      else $error("scratch reserved bits not zero");
   frame_rsvd_a: assert property (
      rvalid && cmd_q == `CMD_FRAME_RD |-> rdata[15:11] == 5'h00)
      else $error("frame reserved bits not zero");
   ident_word_a: assert property (
      rvalid && cmd_q == `CMD_IDENT_RD |->
         rdata == {`PART_CODE, `SILICON_VER})
      else $error("identity word wrong");
   flag_rsvd_a: assert property (
      rvalid && cmd_q == `CMD_INT_RD && !idx_q |-> rdata[15:8] == 8'h00)
      else $error("flag reserved bits not zero");
   scratch_wr_a: assert property (
      wr && !command_data_select && cmd_q == `CMD_SCRATCH_WR
         |-> wdata[15:13] == 3'h0)
      else $error("scratch write with reserved bits set");
endmodule : usb_cmd_bus_chk

/* sim/usb_device_general_command_regs_tb_top.sv */
// bench joining host and device ends, driving software port and events
`timescale 1ns/10ps
`include "usb_cmd_regs_cfg.svh"
module usb_device_general_command_regs_tb_top;
   // short tick period keeps the sleep scenario within a few thousand cycles
   localparam int P = 2000;
   logic        clk;
   logic        reset_n;
   logic [3:0]  addr;
   logic [15:0] wdata;
   logic        wr;
   logic        rd;
   logic [15:0] rdata;
   logic        sof_det;
   logic [10:0] sof_frame;
   logic        resume_det;
   logic        bus_reset_det;
   logic [15:0] ep_event;
   logic        sp_end;
   logic        dma_end;
   logic [31:0] int_enable;
   logic        irq;
   logic        bus_sleep_state;
   int          err_total;
   int          check_count;

   usb_cmd_bus_if bus_if ();
   usb_cmd_host usb_cmd_host_inst (.clk(clk), .reset_n(reset_n),
      .addr(addr), .wdata(wdata), .wr(wr), .rd(rd), .rdata(rdata),
      .bus(bus_if.host));
   usb_cmd_regs_dev #(.PSEUDO_FRAME_TICK_CYCLES(P)) usb_cmd_regs_dev_inst (.clk(clk),
      .reset_n(reset_n), .bus(bus_if.dev), .sof_det(sof_det),
      .sof_frame(sof_frame), .resume_det(resume_det),
      .bus_reset_det(bus_reset_det), .ep_event(ep_event),
      .short_packet_transfer_end(sp_end), .dma_transfer_end(dma_end),
      .int_enable(int_enable), .irq(irq),
      .bus_sleep_state(bus_sleep_state));
   usb_cmd_bus_chk usb_cmd_bus_chk_inst (.clk(clk), .reset_n(reset_n),
      .command_data_select(bus_if.command_data_select), .wr(bus_if.wr),
      .rd(bus_if.rd), .wdata(bus_if.wdata), .rdata(bus_if.rdata),
      .rvalid(bus_if.rvalid));

   // ------------------------------------------------------------
   // tasks
   // ------------------------------------------------------------
   task automatic check(input logic [31:0] seen, input logic [31:0] exp);
      check_count++;
      if (seen !== exp) begin
         err_total++;
         $display("[FAIL] %0t seen %h expected %h", $time, seen, exp);
      end
   endtask : check

   task automatic summarize();
      $display("checks %0d mismatches %0d", check_count, err_total);
      if (err_total == 0 && check_count > 0) begin
         $display("STATUS OK");
      end else begin
         $display("STATUS NOT OK");
      end
      $finish;
   endtask : summarize

   task automatic sw_wr(input logic [3:0] a, input logic [15:0] d);
      @(posedge clk);
      addr <= a;
      wdata <= d;
      wr <= 1'b1;
      @(posedge clk);
      wr <= 1'b0;
   endtask : sw_wr

   task automatic sw_rd(input logic [3:0] a, output logic [15:0] d);
      @(posedge clk);
      addr <= a;
      rd <= 1'b1;
      @(posedge clk);
      rd <= 1'b0;
      #1 d = rdata;
   endtask : sw_rd

   // one whole command; single-word answers come back zero-extended
   task automatic do_cmd(input logic [7:0] code, input logic [15:0] wd,
                         output logic [31:0] r);
      logic [15:0] st;
      logic [15:0] lo;
      logic [15:0] hi;
      int          n;
      sw_wr(`HREG_WDATA, wd);
      sw_wr(`HREG_CMD, {8'h00, code});
      n = 0;
      st = 16'h0001;
      while (st[0] !== 1'b0 && n < 50) begin
         sw_rd(`HREG_STATUS, st);
         n++;
      end
      check({31'h0, st[0]}, 32'h0);
      sw_rd(`HREG_RDATA0, lo);
      sw_rd(`HREG_RDATA1, hi);
      r = (code == `CMD_INT_RD) ? {hi, lo} : {16'h0000, lo};
   endtask : do_cmd

   // k: 0 sof, 1 resume, 2 bus reset, 3 short packet end, 4 dma end
   task automatic pulse_ev(input logic [15:0] ep, input logic [4:0] k,
                           input logic [10:0] fr);
      @(posedge clk);
      ep_event <= ep;
      sof_frame <= fr;
      {dma_end, sp_end, bus_reset_det, resume_det, sof_det} <= k;
      @(posedge clk);
      ep_event <= 16'h0000;
      {dma_end, sp_end, bus_reset_det, resume_det, sof_det} <= 5'h00;
   endtask : pulse_ev

   // ------------------------------------------------------------
   // scenarios
   // ------------------------------------------------------------
   task automatic t_reset();
      logic [31:0] r;
      logic [15:0] d;
      do_cmd(`CMD_SCRATCH_RD, 16'h0000, r);
      check(r, 32'h0000_0000);
      // firmware reads identity right after the scratch read to learn the feature set
      do_cmd(`CMD_IDENT_RD, 16'h0000, r);
      check(r, {16'h0000, `PART_CODE, `SILICON_VER});
      do_cmd(`CMD_INT_RD, 16'h0000, r);
      check(r, 32'h0000_0000);
      sw_rd(4'hF, d);
      check({16'h0000, d}, 32'h0000_0000);
      $display("test reset done");
   endtask : t_reset

   task automatic t_scratch();
      logic [31:0] r;
      do_cmd(`CMD_SCRATCH_WR, 16'hFFFF, r);
      do_cmd(`CMD_SCRATCH_RD, 16'h0000, r);
      check(r, 32'h0000_1FFF);
      do_cmd(`CMD_SCRATCH_WR, 16'h1234, r);
      do_cmd(`CMD_SCRATCH_RD, 16'h0000, r);
      check(r, 32'h0000_1234);
      $display("test scratch done");
   endtask : t_scratch

   task automatic t_frame();
      logic [31:0] r;
      // frame is only read after a good SOF, never right after bus reset
      pulse_ev(16'h0000, 5'h01, 11'h5A5);
      do_cmd(`CMD_FRAME_RD, 16'h0000, r);
      check(r, 32'h0000_05A5);
      pulse_ev(16'h0000, 5'h01, 11'h7FF);
      do_cmd(`CMD_FRAME_RD, 16'h0000, r);
      check(r, 32'h0000_07FF);
      $display("test frame done");
   endtask : t_frame

   task automatic t_flags();
      logic [31:0] r;
      do_cmd(`CMD_INT_RD, 16'h0000, r);
      pulse_ev(16'hFFFF, 5'h1F, 11'h123);
      repeat (3) @(posedge clk);
      #1 check({31'h0, irq}, 32'h0);
      int_enable <= 32'h0000_0008;
      repeat (3) @(posedge clk);
      #1 check({31'h0, irq}, 32'h1);
      do_cmd(`CMD_INT_RD, 16'h0000, r);
      check(r, 32'h00FF_FF5B);
      do_cmd(`CMD_INT_RD, 16'h0000, r);
      check(r, 32'h0000_0000);
      check({31'h0, irq}, 32'h0);
      $display("test flags done");
   endtask : t_flags

   task automatic t_sleep();
      logic [31:0] r;
      int          n;
      pulse_ev(16'h0000, 5'h01, 11'h000);
      n = 0;
      // the tick interval holding the SOF is not a miss, so sleep comes
      // on the third tick after that one: between 3 and 4 periods
      while (bus_sleep_state !== 1'b1 && n < 5 * P) begin
         @(posedge clk);
         n++;
      end
      check({31'h0, n > 2 * P && n <= 4 * P + 8}, 32'h1);
      do_cmd(`CMD_INT_RD, 16'h0000, r);
      check(r & 32'h0000_00A4, 32'h0000_00A4);
      do_cmd(`CMD_INT_RD, 16'h0000, r);
      check(r & 32'h0000_0080, 32'h0000_0080);
      do_cmd(`CMD_SCRATCH_WR, 16'h0ABC, r);
      do_cmd(`CMD_SCRATCH_RD, 16'h0000, r);
      check(r, 32'h0000_1234);
      pulse_ev(16'h0000, 5'h02, 11'h000);
      repeat (2) @(posedge clk);
      #1 check({31'h0, bus_sleep_state}, 32'h0);
      do_cmd(`CMD_INT_RD, 16'h0000, r);
      check(r & 32'h0000_0082, 32'h0000_0002);
      // locked, wrong key, right key
      for (int i = 0; i < 3; i++) begin
         if (i > 0) do_cmd(`CMD_UNLOCK, (i == 1) ? 16'h1234 : `UNLOCK_CODE, r);
         do_cmd(`CMD_SCRATCH_WR, 16'h0ABC, r);
         do_cmd(`CMD_SCRATCH_RD, 16'h0000, r);
         check(r, (i == 2) ? 32'h0000_0ABC : 32'h0000_1234);
      end
      $display("test sleep done");
   endtask : t_sleep

   initial begin
      clk = 1'b0;
      forever #25 clk = ~clk;
   end

   initial begin
      repeat (20000) @(posedge clk);
      err_total++;
      summarize();
   end

   initial begin
      reset_n = 1'b0;
      addr = 4'h0;
      wdata = 16'h0000;
      wr = 1'b0;
      rd = 1'b0;
      {dma_end, sp_end, bus_reset_det, resume_det, sof_det} = 5'h00;
      sof_frame = 11'h000;
      ep_event = 16'h0000;
      int_enable = 32'h0000_0000;
      err_total = 0;
      check_count = 0;
      repeat (16) @(posedge clk);
      reset_n <= 1'b1;
      t_reset();
      t_scratch();
      t_frame();
      t_flags();
      t_sleep();
      summarize();
   end
endmodule : usb_device_general_command_regs_tb_top
